//--- rtl/ifd_pkg.sv
// Package with offsets, field positions, reset values and codes for the input format and display mode registers.
`default_nettype none
package ifd_pkg;
  localparam logic [7:0] IFD_OFS_INPUT_FORMAT = 8'h2a;
  localparam logic [7:0] IFD_OFS_CONV_CTRL = 8'h2c;
  localparam logic [7:0] IFD_OFS_CONV_RANGE = 8'h2e;
  localparam logic [7:0] IFD_OFS_FIXED_U = 8'h30;
  localparam logic [7:0] IFD_OFS_FIXED_V = 8'h32;
  localparam logic [7:0] IFD_OFS_BLANK_ROT = 8'h34;
  localparam logic [7:0] IFD_OFS_WIN_BUF = 8'h36;

  localparam logic [7:0] IFD_RST_INPUT_FORMAT = 8'h01;
  localparam logic [7:0] IFD_RST_CONV_CTRL = 8'h00;
  localparam logic [7:0] IFD_RST_CONV_RANGE = 8'h05;
  localparam logic [7:0] IFD_RST_FIXED_U = 8'h00;
  localparam logic [7:0] IFD_RST_FIXED_V = 8'h00;
  localparam logic [7:0] IFD_RST_BLANK_ROT = 8'h00;
  localparam logic [7:0] IFD_RST_WIN_BUF = 8'h00;

  localparam logic [7:0] IFD_MASK_INPUT_FORMAT = 8'h8f;
  localparam logic [7:0] IFD_MASK_CONV_CTRL = 8'h70;
  localparam logic [7:0] IFD_MASK_CONV_RANGE = 8'h37;
  localparam logic [7:0] IFD_MASK_BLANK_ROT = 8'h83;
  localparam logic [7:0] IFD_MASK_WIN_BUF = 8'hc3;

  localparam int IFD_BIT_STORE18 = 7;
  localparam int IFD_BIT_CONV_RESET = 6;
  localparam int IFD_POS_CHROMA_SEL = 4;
  localparam int IFD_POS_RANGE_SEL = 4;
  localparam int IFD_BIT_BLANK = 7;
  localparam int IFD_BIT_WIN_DOUBLE = 7;
  localparam int IFD_BIT_DBUF_EN = 6;

  localparam logic [3:0] IFD_FMT_RGB565 = 4'h1;
  localparam logic [3:0] IFD_FMT_RGB666_V1 = 4'h2;
  localparam logic [3:0] IFD_FMT_RGB888_V1 = 4'h3;
  localparam logic [3:0] IFD_FMT_RGB666_V2 = 4'h6;
  localparam logic [3:0] IFD_FMT_RGB888_V2 = 4'h7;
  localparam logic [3:0] IFD_FMT_YUV422 = 4'h8;
  localparam logic [3:0] IFD_FMT_YUV420 = 4'h9;

  localparam logic [2:0] IFD_XFER_BT709 = 3'h1;
  localparam logic [2:0] IFD_XFER_BT470M = 3'h4;
  localparam logic [2:0] IFD_XFER_BT601 = 3'h5;
  localparam logic [2:0] IFD_XFER_SMPTE170 = 3'h6;
  localparam logic [2:0] IFD_XFER_SMPTE240 = 3'h7;

  localparam logic [19:0] IFD_BUF_BYTES_16 = 20'hc0000;
  localparam logic [19:0] IFD_BUF_BYTES_18 = 20'ha0000;

  typedef enum logic [2:0] {
    IFD_CONV_RUN = 3'b001,
    IFD_CONV_RESET = 3'b010,
    IFD_CONV_RELEASE = 3'b100
  } ifd_conv_state_t;
endpackage
`default_nettype wire

//--- rtl/ifd_chroma_mux.sv
// Chroma override selection feeding the colour space converter.
`timescale 1ns/100ps
`default_nettype none
module ifd_chroma_mux (
  input wire logic [1:0] sel_i,
  input wire logic [7:0] u_in_i,
  input wire logic [7:0] v_in_i,
  input wire logic [7:0] fixed_u_i,
  input wire logic [7:0] fixed_v_i,
  output logic [7:0] u_o,
  output logic [7:0] v_o
);
  wire use_fixed_u = sel_i[0];
  wire use_fixed_v = sel_i[1];
  assign u_o = use_fixed_u ? fixed_u_i : u_in_i;
  assign v_o = use_fixed_v ? fixed_v_i : v_in_i;
endmodule
`default_nettype wire

//--- rtl/ifd_regs.sv
// Input format, converter and display mode registers with their decoded controls.
// Function
// - Storage bit clear keeps 16 bpp truncating 18; set keeps 18 bpp expanding 16.
// - In 18 bpp storage the main image gets 640KB; upper region holds extra bits.
// - In 16 bpp storage the whole 768K byte buffer holds pixel data.
// - Decode the four-bit input format code; other codes are reserved.
// - Both 8:8:8 variants drop low colour bits to fit the storage depth.
// - Variant-1 odd-width lines ignore the last red; host resends it with green.
// - Converter reset bit holds converter in reset while 1 and reads back state.
// - Chroma override select chooses original or fixed U and V.
// - Fixed U drives the converter only for select 01 or 11.
// - Fixed V drives the converter only for select 10 or 11.
// - Two-bit range select tells the converter the input component ranges.
// - Three-bit transfer mode chooses coefficients; 000, 010, 011 reserved.
// - Blank bit disables the panel pipeline and forces panel data to zero.
// - Rotation select rotates window data 0, 90, 180 or 270 degrees before storage.
// - Window data type marks single or double buffered data; the double flag latches at window start.
// - Double buffering is active only when the image fits half the usable buffer.
// - Only one window is double buffered; others are single buffered.
// - Type 0 with buffering protects the double window; type 1 without is reserved.
// - Pixel sizing 00 unscaled, 01 doubles, 10 halves.
`timescale 1ns/100ps
`default_nettype none
module ifd_regs
  import ifd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [19:0] image_bytes_i,
  input wire logic window_start_i,
  input wire logic converter_busy_i,
  input wire logic [7:0] conv_u_in_i,
  input wire logic [7:0] conv_v_in_i,
  input wire logic [17:0] panel_data_in_i,
  output logic store_18bpp_o,
  output logic truncate_input_o,
  output logic expand_input_o,
  output logic [19:0] image_limit_o,
  output logic [19:0] extra_bits_base_o,
  output logic [3:0] input_format_o,
  output logic fmt_rgb565_o,
  output logic fmt_rgb666_o,
  output logic fmt_rgb888_o,
  output logic fmt_variant1_o,
  output logic fmt_yuv422_o,
  output logic fmt_yuv420_o,
  output logic fmt_reserved_o,
  output logic drop_low_bits_o,
  output logic odd_red_ignore_o,
  output logic converter_reset_o,
  output logic [7:0] conv_u_o,
  output logic [7:0] conv_v_o,
  output logic [1:0] conv_range_o,
  output logic [2:0] conv_xfer_mode_o,
  output logic conv_xfer_reserved_o,
  output logic pipeline_enable_o,
  output logic [17:0] panel_data_o,
  output logic [1:0] rotation_o,
  output logic window_double_o,
  output logic double_buffer_active_o,
  output logic protect_double_window_o,
  output logic buffer_combo_reserved_o,
  output logic [1:0] latched_window_double_o,
  output logic [1:0] pixel_sizing_o,
  output logic sizing_double_o,
  output logic sizing_half_o
);
  import ifd_pkg::*;

  logic [7:0] input_format_cfg_q, input_format_cfg_d;
  logic [7:0] converter_control_q, converter_control_d;
  logic [7:0] converter_range_coeff_cfg_q, converter_range_coeff_cfg_d;
  logic [7:0] fixed_u_value_q, fixed_u_value_d;
  logic [7:0] fixed_v_value_q, fixed_v_value_d;
  logic [7:0] display_blank_rotation_q, display_blank_rotation_d;
  logic [7:0] window_buffer_sizing_q, window_buffer_sizing_d;
  logic [7:0] rdata_q, rdata_d;
  logic [17:0] panel_q, panel_d;
  logic win_double_q, win_double_d;
  logic win_latched_q, win_latched_d;
  ifd_conv_state_t conv_state_q, conv_state_d;

  function automatic logic [7:0] merge_write(input logic [7:0] wdata, input logic [7:0] mask);
    merge_write = wdata & mask;
  endfunction

  wire hit_fmt = reg_addr_i == IFD_OFS_INPUT_FORMAT;
  wire hit_ctrl = reg_addr_i == IFD_OFS_CONV_CTRL;
  wire hit_range = reg_addr_i == IFD_OFS_CONV_RANGE;
  wire hit_u = reg_addr_i == IFD_OFS_FIXED_U;
  wire hit_v = reg_addr_i == IFD_OFS_FIXED_V;
  wire hit_blank = reg_addr_i == IFD_OFS_BLANK_ROT;
  wire hit_win = reg_addr_i == IFD_OFS_WIN_BUF;

  // Masked writes keep unused and reserved positions at zero.
  assign input_format_cfg_d = (reg_write_i && hit_fmt) ?
                              merge_write(reg_wdata_i, IFD_MASK_INPUT_FORMAT) : input_format_cfg_q;
  assign converter_control_d = (reg_write_i && hit_ctrl) ?
                               merge_write(reg_wdata_i, IFD_MASK_CONV_CTRL) : converter_control_q;
  assign converter_range_coeff_cfg_d = (reg_write_i && hit_range) ?
                                       merge_write(reg_wdata_i, IFD_MASK_CONV_RANGE) :
                                       converter_range_coeff_cfg_q;
  assign fixed_u_value_d = (reg_write_i && hit_u) ? reg_wdata_i : fixed_u_value_q;
  assign fixed_v_value_d = (reg_write_i && hit_v) ? reg_wdata_i : fixed_v_value_q;
  assign display_blank_rotation_d = (reg_write_i && hit_blank) ?
                                    merge_write(reg_wdata_i, IFD_MASK_BLANK_ROT) : display_blank_rotation_q;
  assign window_buffer_sizing_d = (reg_write_i && hit_win) ?
                                  merge_write(reg_wdata_i, IFD_MASK_WIN_BUF) : window_buffer_sizing_q;

  // Read mux; unmapped offsets read zero.
  assign rdata_d = !reg_read_i ? rdata_q :
                   hit_fmt ? input_format_cfg_q :
                   hit_ctrl ? {1'b0, converter_reset_o, converter_control_q[5:0]} :
                   hit_range ? converter_range_coeff_cfg_q :
                   hit_u ? fixed_u_value_q :
                   hit_v ? fixed_v_value_q :
                   hit_blank ? display_blank_rotation_q :
                   hit_win ? window_buffer_sizing_q : 8'h00;
  assign reg_rdata_o = rdata_q;

  // Storage depth and memory split.
  assign store_18bpp_o = input_format_cfg_q[IFD_BIT_STORE18];
  assign input_format_o = input_format_cfg_q[3:0];
  wire input_is_18 = fmt_rgb666_o || fmt_rgb888_o || fmt_yuv422_o || fmt_yuv420_o;
  assign truncate_input_o = !store_18bpp_o && input_is_18;
  assign expand_input_o = store_18bpp_o && fmt_rgb565_o;
  assign image_limit_o = store_18bpp_o ? IFD_BUF_BYTES_18 : IFD_BUF_BYTES_16;
  assign extra_bits_base_o = IFD_BUF_BYTES_18;

  // Input format decode.
  assign fmt_rgb565_o = input_format_o == IFD_FMT_RGB565;
  assign fmt_rgb666_o = input_format_o == IFD_FMT_RGB666_V1 || input_format_o == IFD_FMT_RGB666_V2;
  assign fmt_rgb888_o = input_format_o == IFD_FMT_RGB888_V1 || input_format_o == IFD_FMT_RGB888_V2;
  assign fmt_variant1_o = input_format_o == IFD_FMT_RGB666_V1 || input_format_o == IFD_FMT_RGB888_V1;
  assign fmt_yuv422_o = input_format_o == IFD_FMT_YUV422;
  assign fmt_yuv420_o = input_format_o == IFD_FMT_YUV420;
  assign fmt_reserved_o = !(fmt_rgb565_o || input_is_18);
  assign drop_low_bits_o = fmt_rgb888_o;
  assign odd_red_ignore_o = fmt_variant1_o;

  // Converter reset: held while the bit is one, released through one clean cycle.
  always_comb begin
    conv_state_d = conv_state_q;
    unique case (conv_state_q)
      IFD_CONV_RUN: begin
        if (converter_control_q[IFD_BIT_CONV_RESET]) begin
          conv_state_d = IFD_CONV_RESET;
        end
      end
      IFD_CONV_RESET: begin
        if (!converter_control_q[IFD_BIT_CONV_RESET]) begin
          conv_state_d = IFD_CONV_RELEASE;
        end
      end
      IFD_CONV_RELEASE: begin
        conv_state_d = converter_control_q[IFD_BIT_CONV_RESET] ? IFD_CONV_RESET : IFD_CONV_RUN;
      end
      default: begin
        conv_state_d = IFD_CONV_RUN;
      end
    endcase
  end
  assign converter_reset_o = converter_control_q[IFD_BIT_CONV_RESET] || conv_state_q == IFD_CONV_RESET;

  ifd_chroma_mux u_chroma (
    .sel_i(converter_control_q[IFD_POS_CHROMA_SEL +: 2]),
    .u_in_i(conv_u_in_i),
    .v_in_i(conv_v_in_i),
    .fixed_u_i(fixed_u_value_q),
    .fixed_v_i(fixed_v_value_q),
    .u_o(conv_u_o),
    .v_o(conv_v_o)
  );

  assign conv_range_o = converter_range_coeff_cfg_q[IFD_POS_RANGE_SEL +: 2];
  assign conv_xfer_mode_o = converter_range_coeff_cfg_q[2:0];
  assign conv_xfer_reserved_o = !(conv_xfer_mode_o == IFD_XFER_BT709 || conv_xfer_mode_o == IFD_XFER_BT470M ||
                                  conv_xfer_mode_o == IFD_XFER_BT601 || conv_xfer_mode_o == IFD_XFER_SMPTE170 ||
                                  conv_xfer_mode_o == IFD_XFER_SMPTE240);

  // Blanking forces panel data to zero from a register.
  assign pipeline_enable_o = !display_blank_rotation_q[IFD_BIT_BLANK];
  assign panel_d = pipeline_enable_o ? panel_data_in_i : 18'h00000;
  assign panel_data_o = panel_q;
  assign rotation_o = display_blank_rotation_q[1:0];

  // Window buffering.
  assign window_double_o = window_buffer_sizing_q[IFD_BIT_WIN_DOUBLE];
  wire dbuf_en = window_buffer_sizing_q[IFD_BIT_DBUF_EN];
  wire fits_half = image_bytes_i <= (image_limit_o >> 1);
  assign double_buffer_active_o = dbuf_en && fits_half;
  assign protect_double_window_o = !window_double_o && double_buffer_active_o;
  assign buffer_combo_reserved_o = window_double_o && !dbuf_en;
  // Only the latest window's double-buffered flag is remembered; each window start replaces it.
  wire take_double = window_double_o && double_buffer_active_o;
  assign win_double_d = window_start_i ? take_double : win_double_q;
  assign win_latched_d = window_start_i ? 1'b1 : win_latched_q;
  assign latched_window_double_o = {win_latched_q, win_double_q};
  assign pixel_sizing_o = window_buffer_sizing_q[1:0];
  assign sizing_double_o = pixel_sizing_o == 2'b01;
  assign sizing_half_o = pixel_sizing_o == 2'b10;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      input_format_cfg_q <= IFD_RST_INPUT_FORMAT;
      converter_control_q <= IFD_RST_CONV_CTRL;
      converter_range_coeff_cfg_q <= IFD_RST_CONV_RANGE;
      fixed_u_value_q <= IFD_RST_FIXED_U;
      fixed_v_value_q <= IFD_RST_FIXED_V;
      display_blank_rotation_q <= IFD_RST_BLANK_ROT;
      window_buffer_sizing_q <= IFD_RST_WIN_BUF;
      rdata_q <= 8'h00;
      panel_q <= 18'h00000;
      win_double_q <= 1'b0;
      win_latched_q <= 1'b0;
      conv_state_q <= IFD_CONV_RUN;
    end else begin
      input_format_cfg_q <= input_format_cfg_d;
      converter_control_q <= converter_control_d;
      converter_range_coeff_cfg_q <= converter_range_coeff_cfg_d;
      fixed_u_value_q <= fixed_u_value_d;
      fixed_v_value_q <= fixed_v_value_d;
      display_blank_rotation_q <= display_blank_rotation_d;
      window_buffer_sizing_q <= window_buffer_sizing_d;
      rdata_q <= rdata_d;
      panel_q <= panel_d;
      win_double_q <= win_double_d;
      win_latched_q <= win_latched_d;
      conv_state_q <= conv_state_d;
    end
  end

  wire unused_busy = converter_busy_i;
endmodule
`default_nettype wire

//--- sim/ifd_regs_sva.sv
// Assertion checker for the input format and display mode registers.
`timescale 1ns/100ps
`default_nettype none
module ifd_regs_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] conv_u_in_i,
  input wire logic [7:0] conv_v_in_i,
  input wire logic [17:0] panel_data_in_i,
  input wire logic [7:0] conv_u_o,
  input wire logic [7:0] conv_v_o,
  input wire logic converter_reset_o,
  input wire logic store_18bpp_o,
  input wire logic [19:0] image_limit_o,
  input wire logic pipeline_enable_o,
  input wire logic [17:0] panel_data_o,
  input wire logic double_buffer_active_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_ctl_wr;
    reg_write_i && reg_addr_i == 8'h2c;
  endsequence
  sequence s_odd_rd;
    reg_read_i && !(reg_addr_i inside {8'h2a, 8'h2c, 8'h2e, 8'h30, 8'h32, 8'h34, 8'h36});
  endsequence
  a_store_select: assert property (reg_write_i && reg_addr_i == 8'h2a
    |=> store_18bpp_o == $past(reg_wdata_i[7]))
    else $error("storage depth does not follow the written bit");
  a_limit_depth: assert property (image_limit_o == (store_18bpp_o ? 20'ha0000 : 20'hc0000))
    else $error("image limit does not match storage depth");
  a_conv_reset_set: assert property (s_ctl_wr ##0 reg_wdata_i[6] |=> converter_reset_o)
    else $error("converter not held in reset");
  a_u_pass: assert property (s_ctl_wr ##0 !reg_wdata_i[4] |=> conv_u_o == conv_u_in_i)
    else $error("fixed u used while not selected");
  a_v_pass: assert property (s_ctl_wr ##0 !reg_wdata_i[5] |=> conv_v_o == conv_v_in_i)
    else $error("fixed v used while not selected");
  a_blank_zero: assert property (!pipeline_enable_o |=> panel_data_o == 18'h00000)
    else $error("panel data not zero while blanked");
  a_pipe_pass: assert property (pipeline_enable_o |=> panel_data_o == $past(panel_data_in_i))
    else $error("panel data not passed while enabled");
  a_dbuf_off: assert property (reg_write_i && reg_addr_i == 8'h36 && !reg_wdata_i[6]
    |=> !double_buffer_active_o)
    else $error("double buffer active while disabled");
  a_unmapped_zero: assert property (s_odd_rd |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_read_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
endmodule
bind ifd_regs ifd_regs_chk u_ifd_regs_chk (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .conv_u_in_i, .conv_v_in_i, .panel_data_in_i, .conv_u_o, .conv_v_o,
  .converter_reset_o, .store_18bpp_o, .image_limit_o, .pipeline_enable_o, .panel_data_o, .double_buffer_active_o);
`default_nettype wire

//--- sim/ifd_host_model.sv
// Host processor model issuing register writes and reads.
`timescale 1ns/100ps
`default_nettype none
module ifd_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic write_o,
  output logic read_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    write_o = 1'b0;
    read_o = 1'b0;
  end
  // Idle bus lines show the inverse so stale values never pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    write_o = 1'b1;
    @(negedge ref_clk_i);
    write_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    read_o = 1'b1;
    @(negedge ref_clk_i);
    read_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

//--- sim/test_input_format_and_display_mode_regs.sv
// Testbench for the input format and display mode registers.
`timescale 1ns/100ps
`default_nettype none
module test_input_format_and_display_mode_regs;
  import ifd_pkg::*;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, window_start_i = 1'b0, converter_busy_i = 1'b0;
  logic [19:0] image_bytes_i = 20'h00000;
  logic [7:0] conv_u_in_i = 8'h11, conv_v_in_i = 8'h22, reg_rdata_o, conv_u_o, conv_v_o;
  logic [17:0] panel_data_in_i = 18'h2aaaa, panel_data_o;
  wire logic [7:0] reg_addr_i, reg_wdata_i;
  wire logic reg_write_i, reg_read_i;
  logic store_18bpp_o, expand_input_o, fmt_reserved_o, drop_low_bits_o, odd_red_ignore_o, converter_reset_o;
  logic conv_xfer_reserved_o, double_buffer_active_o, protect_double_window_o, buffer_combo_reserved_o;
  logic sizing_double_o, sizing_half_o;
  logic truncate_input_o, fmt_rgb565_o, fmt_rgb666_o, fmt_rgb888_o, fmt_variant1_o, fmt_yuv422_o, fmt_yuv420_o;
  logic pipeline_enable_o, window_double_o;
  logic [1:0] conv_range_o, rotation_o, latched_window_double_o, pixel_sizing_o;
  logic [2:0] conv_xfer_mode_o;
  logic [3:0] input_format_o;
  logic [19:0] image_limit_o, extra_bits_base_o;
  int miscompares = 0, checks_done = 0, cycles = 0;
  logic [7:0] rstv [7] = '{8'h01, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mskv [7] = '{8'h8f, 8'h70, 8'h37, 8'hff, 8'hff, 8'h83, 8'hc3};
  always #2.5 ref_clk_i = ~ref_clk_i;
  ifd_host_model u_ifd_host_model (.ref_clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
    .write_o(reg_write_i), .read_o(reg_read_i));
  ifd_regs u_ifd_regs (.*);
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_out(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_ifd_host_model.rd(a, d);
    checks_done++;
    if (d !== exp) begin
      miscompares++;
      $display("mismatch at %0t read %h expected %h", $time, d, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ifd_host_model.wr(a, d);
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    @(negedge ref_clk_i) reset_i = 1'b0;
    for (int i = 0; i < 7; i++) chk_rd(8'h2a + 8'(2 * i), rstv[i]);
    for (int i = 0; i < 7; i++) begin
      wr(8'h2a + 8'(2 * i), 8'hff);
      chk_rd(8'h2a + 8'(2 * i), mskv[i]);
    end
    wr(8'h2b, 8'h5a);
    chk_rd(8'h2b, 8'h00);
    wr(8'h2c, 8'h40);
    chk_out(20'(converter_reset_o), 20'h1);
    chk_rd(8'h2c, 8'h40);
    wr(8'h2c, 8'h00);
    chk_out(20'(converter_reset_o), 20'h1);
    @(negedge ref_clk_i);
    chk_out(20'(converter_reset_o), 20'h0);
    wr(8'h30, 8'ha5);
    wr(8'h32, 8'h3c);
    for (int s = 0; s < 4; s++) begin
      wr(8'h2c, 8'(s << 4));
      chk_out(20'(conv_u_o), s[0] ? 20'ha5 : 20'h11);
      chk_out(20'(conv_v_o), s[1] ? 20'h3c : 20'h22);
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h2a, 8'(i));
      chk_out(20'(fmt_reserved_o), 20'(!(i inside {1, 2, 3, 6, 7, 8, 9})));
      chk_out(20'(input_format_o), 20'(i));
      chk_out(20'(fmt_rgb565_o), 20'(i == 1));
      chk_out(20'(fmt_rgb666_o), 20'(i == 2 || i == 6));
      chk_out(20'(fmt_rgb888_o), 20'(i == 3 || i == 7));
      chk_out(20'(fmt_variant1_o), 20'(i == 2 || i == 3));
      chk_out(20'(fmt_yuv422_o), 20'(i == 8));
      chk_out(20'(fmt_yuv420_o), 20'(i == 9));
      chk_out(20'(truncate_input_o), 20'(i inside {2, 3, 6, 7, 8, 9}));
      chk_out(20'(drop_low_bits_o), 20'(i == 3 || i == 7));
      chk_out(20'(odd_red_ignore_o), 20'(i == 2 || i == 3));
    end
    wr(8'h2a, 8'h81);
    chk_out(20'(store_18bpp_o), 20'h1);
    chk_out(20'(expand_input_o), 20'h1);
    chk_out(image_limit_o, 20'ha0000);
    chk_out(extra_bits_base_o, 20'ha0000);
    chk_out(20'(truncate_input_o), 20'h0);
    wr(8'h2a, 8'h03);
    chk_out(image_limit_o, 20'hc0000);
    chk_out(20'(truncate_input_o), 20'h1);
    for (int j = 0; j < 8; j++) begin
      wr(8'h2e, {2'b00, 2'(j), 1'b0, 3'(j)});
      chk_out(20'(conv_range_o), 20'(j % 4));
      chk_out(20'(conv_xfer_reserved_o), 20'(j inside {0, 2, 3}));
      chk_out(20'(conv_xfer_mode_o), 20'(j));
    end
    wr(8'h34, 8'h83);
    chk_out(20'(pipeline_enable_o), 20'h0);
    @(negedge ref_clk_i);
    chk_out(20'(panel_data_o), 20'h0);
    chk_out(20'(rotation_o), 20'h3);
    wr(8'h34, 8'h02);
    chk_out(20'(pipeline_enable_o), 20'h1);
    @(negedge ref_clk_i);
    chk_out(20'(panel_data_o), 20'h2aaaa);
    chk_out(20'(rotation_o), 20'h2);
    image_bytes_i = 20'h60000;
    wr(8'h36, 8'hc1);
    chk_out(20'(double_buffer_active_o), 20'h1);
    chk_out(20'(sizing_double_o), 20'h1);
    chk_out(20'(pixel_sizing_o), 20'h1);
    chk_out(20'(window_double_o), 20'h1);
    window_start_i = 1'b1;
    @(negedge ref_clk_i) window_start_i = 1'b0;
    chk_out(20'(latched_window_double_o), 20'h3);
    image_bytes_i = 20'h60001;
    @(negedge ref_clk_i);
    chk_out(20'(double_buffer_active_o), 20'h0);
    image_bytes_i = 20'h60000;
    wr(8'h36, 8'h42);
    chk_out(20'(protect_double_window_o), 20'h1);
    chk_out(20'(sizing_half_o), 20'h1);
    window_start_i = 1'b1;
    @(negedge ref_clk_i) window_start_i = 1'b0;
    chk_out(20'(latched_window_double_o), 20'h2);
    wr(8'h36, 8'h80);
    chk_out(20'(buffer_combo_reserved_o), 20'h1);
    finish_test();
  end
endmodule
`default_nettype wire
